// ---- src/keypad_defines.svh ----
// Register indexes, field positions, reset values and timing counts of the keypad scanner.
// Assumes a 1 kHz tick enable produced on the system clock outside this block.
`ifndef KEYPAD_DEFINES_SVH
`define KEYPAD_DEFINES_SVH

// Register indexes; the APB byte address is four times the index.
`define KP_IDX_COLUMN_DRIVE 10'h0d1
`define KP_IDX_ROW_SENSE 10'h0d2
`define KP_IDX_TIMING 10'h0d3
`define KP_IDX_CONTROL_STATUS 10'h0d4
`define KP_IDX_ORDER_LOW 10'h0d5
`define KP_IDX_ORDER_HIGH 10'h0d6
`define KP_IDX_DIMENSION 10'h0d7
`define KP_IDX_CLOCK_CONTROL 10'h0d8

// Reset values.
`define KP_COLUMN_DRIVE_RESET 8'h1f
`define KP_ROW_SENSE_RESET 8'h3f
`define KP_TIMING_RESET 8'h00
`define KP_ORDER_LOW_RESET 9'h088
`define KP_ORDER_HIGH_RESET 6'h23
`define KP_DIMENSION_RESET 8'h65

// Field positions.
`define KP_STAT_DETECT_EN_BIT 0
`define KP_STAT_KEY_FLAG_BIT 1
`define KP_STAT_AUTO_EN_BIT 2
`define KP_STAT_TICK_PHASE_BIT 3
`define KP_CLKCTL_KEYPAD_EN_BIT 6
`define KP_DEBOUNCE_LSB 2
`define KP_DEBOUNCE_MSB 7
`define KP_ROW_CHECK_LSB 0
`define KP_ROW_CHECK_MSB 1
`define KP_DIM_COLS_LSB 0
`define KP_DIM_COLS_MSB 2
`define KP_DIM_ROWS_LSB 4
`define KP_DIM_ROWS_MSB 6
`define KP_ORDER_SLOT_WIDTH 3

// Timing in milliseconds and its count of 1 kHz ticks.
`define KP_TICK_PERIOD_MS 1
`define KP_DEBOUNCE_STEP_MS 4
`define KP_DEBOUNCE_MAX_MS 256
`define KP_ROW_CHECK_MAX_MS 4
`define KP_DEBOUNCE_STEP_TICKS (`KP_DEBOUNCE_STEP_MS / `KP_TICK_PERIOD_MS)
`define KP_DEBOUNCE_MAX_TICKS (`KP_DEBOUNCE_MAX_MS / `KP_TICK_PERIOD_MS)
`define KP_ROW_CHECK_MAX_TICKS (`KP_ROW_CHECK_MAX_MS / `KP_TICK_PERIOD_MS)

`endif

// ---- src/keypad_pkg.sv ----
// Types shared by the keypad scanner.
// Assumes nothing beyond a SystemVerilog compiler.
package keypad_pkg;

  typedef enum logic [2:0] {
    ST_WAIT_PRESS,
    ST_PRESS_DEBOUNCE,
    ST_SCAN,
    ST_WAIT_RELEASE,
    ST_RELEASE_DEBOUNCE
  } scan_state_type;

endpackage

// ---- src/keypad_matrix_scanner.sv ----
// Keypad matrix scanner: APB register slave, press detection, column scan and release debounce.
// Assumes a one-cycle 1 kHz tick enable on clk_sys and asynchronous row pins from the switch matrix.
//
// Chosen here: register access over APB.
`include "keypad_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module keypad_matrix_scanner #(
  parameter int NUM_ROWS = 6,
  parameter int NUM_COLS = 5
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tick_1khz,
  input wire logic [NUM_ROWS-1:0] row_in,
  output logic [NUM_COLS-1:0] col_out,
  output logic [NUM_ROWS-1:0] row_pullup_en,
  output logic [NUM_ROWS-1:0] row_hyst_en,
  output logic key_irq
);

  // ********************************************************
  // Parameter check and state
  // ********************************************************
  // Five order slots of three bits and a three-bit row index bound the sizes.
  if (NUM_COLS < 1 || NUM_COLS > 5 || NUM_ROWS < 1 || NUM_ROWS > 7) begin : g_param_check
    $error("keypad_matrix_scanner: NUM_COLS must be 1..5 and NUM_ROWS 1..7");
  end

  typedef struct packed {
    keypad_pkg::scan_state_type state;
    logic [NUM_COLS-1:0] col_drive;
    logic [NUM_ROWS-1:0] row_hold;
    logic [NUM_COLS-1:0] col_pins;
    logic [7:0] timing;
    logic [8:0] order_low;
    logic [5:0] order_high;
    logic [7:0] dimension;
    logic keypad_clock_enable;
    logic auto_scan_enable;
    logic detect_enable;
    logic key_detect_flag;
    logic tick_phase;
    logic [NUM_ROWS-1:0] row_meta;
    logic [NUM_ROWS-1:0] row_sync;
    logic [NUM_ROWS-1:0] row_prev;
    logic [8:0] timer;
    logic [2:0] slot;
    logic [2:0] row_idx;
    logic [1:0] hits;
    logic [2:0] hit_col;
    logic [2:0] hit_row;
    logic [7:0] rd_data;
    logic rd_err;
  } scanner_state_type;

  scanner_state_type st_ff;
  scanner_state_type nxt_st;

  // ********************************************************
  // Helper functions
  // ********************************************************
  function automatic logic [9:0] reg_index(input logic [11:0] addr);
    reg_index = addr[11:2];
  endfunction

  function automatic logic addr_is(input logic [11:0] addr, input logic [9:0] idx);
    addr_is = (addr[1:0] == 2'h0) && (reg_index(addr) == idx);
  endfunction

  // Zero means one line; values past the pin count clamp to the pin count.
  function automatic logic [2:0] clamp_count(input logic [2:0] v, input logic [2:0] limit);
    if (v == 3'h0) begin
      clamp_count = 3'h1;
    end else if (v > limit) begin
      clamp_count = limit;
    end else begin
      clamp_count = v;
    end
  endfunction

  function automatic logic [2:0] order_slot(input logic [2:0] s, input logic [8:0] lo, input logic [5:0] hi);
    logic [14:0] all_slots;
    all_slots = {hi, lo};
    order_slot = all_slots[s*`KP_ORDER_SLOT_WIDTH +: `KP_ORDER_SLOT_WIDTH];
  endfunction

  // ********************************************************
  // Decoded values
  // ********************************************************
  localparam logic [2:0] MAX_COLS = 3'(NUM_COLS);
  localparam logic [2:0] MAX_ROWS = 3'(NUM_ROWS);

  logic tick_en;
  logic [5:0] debounce_field;
  logic [8:0] debounce_ticks;
  logic [1:0] row_check_field;
  logic [8:0] row_check_ticks;
  logic [2:0] active_cols;
  logic [2:0] active_rows;
  logic [NUM_ROWS-1:0] row_mask;
  logic any_row_low;
  logic all_rows_high;
  logic [2:0] cur_col;
  logic [NUM_COLS-1:0] scan_pattern;
  logic bus_setup;
  logic bus_write;
  logic bus_read_access;
  logic row_fall_edge;

  assign tick_en = tick_1khz & st_ff.keypad_clock_enable;
  assign debounce_field = st_ff.timing[`KP_DEBOUNCE_MSB:`KP_DEBOUNCE_LSB];
  // A zero field selects the longest interval.
  assign debounce_ticks = (debounce_field == 6'h00) ? 9'(`KP_DEBOUNCE_MAX_TICKS)
                          : 9'(debounce_field * `KP_DEBOUNCE_STEP_TICKS);
  assign row_check_field = st_ff.timing[`KP_ROW_CHECK_MSB:`KP_ROW_CHECK_LSB];
  assign row_check_ticks = (row_check_field == 2'h0) ? 9'(`KP_ROW_CHECK_MAX_TICKS)
                           : 9'(row_check_field * `KP_TICK_PERIOD_MS);
  assign active_cols = clamp_count(st_ff.dimension[`KP_DIM_COLS_MSB:`KP_DIM_COLS_LSB], MAX_COLS);
  assign active_rows = clamp_count(st_ff.dimension[`KP_DIM_ROWS_MSB:`KP_DIM_ROWS_LSB], MAX_ROWS);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ROWS; gi = gi + 1) begin : g_row_mask
      assign row_mask[gi] = (3'(gi) < active_rows);
    end
  endgenerate

  assign any_row_low = |(~st_ff.row_sync & row_mask);
  assign all_rows_high = ~any_row_low;
  assign cur_col = order_slot(st_ff.slot, st_ff.order_low, st_ff.order_high);

  // A slot naming a column that does not exist drives nothing low.
  generate
    for (gi = 0; gi < NUM_COLS; gi = gi + 1) begin : g_scan_pattern
      assign scan_pattern[gi] = (cur_col != 3'(gi));
    end
  endgenerate

  assign bus_setup = psel & ~penable;
  assign bus_write = psel & penable & pwrite;
  assign bus_read_access = psel & penable & ~pwrite;
  // Edge detection uses only the synchronised rows, so it needs no tick.
  assign row_fall_edge = (&st_ff.row_prev) & ~(&st_ff.row_sync);

  // ********************************************************
  // Next-state logic
  // ********************************************************
  always_comb begin
    nxt_st = st_ff;

    nxt_st.row_meta = row_in;
    nxt_st.row_sync = st_ff.row_meta;
    nxt_st.row_prev = st_ff.row_sync;

    if (tick_en) begin
      nxt_st.tick_phase = ~st_ff.tick_phase;
    end

    // Register writes from the bus.
    if (bus_write) begin
      if (addr_is(paddr, `KP_IDX_COLUMN_DRIVE)) begin
        nxt_st.col_drive = pwdata[NUM_COLS-1:0];
      end
      if (addr_is(paddr, `KP_IDX_TIMING)) begin
        nxt_st.timing = pwdata[7:0];
      end
      if (addr_is(paddr, `KP_IDX_CONTROL_STATUS)) begin
        nxt_st.auto_scan_enable = pwdata[`KP_STAT_AUTO_EN_BIT];
        nxt_st.detect_enable = pwdata[`KP_STAT_DETECT_EN_BIT];
      end
      if (addr_is(paddr, `KP_IDX_ORDER_LOW)) begin
        nxt_st.order_low = pwdata[8:0];
      end
      if (addr_is(paddr, `KP_IDX_ORDER_HIGH)) begin
        nxt_st.order_high = pwdata[5:0];
      end
      if (addr_is(paddr, `KP_IDX_DIMENSION)) begin
        nxt_st.dimension = pwdata[7:0];
      end
      if (addr_is(paddr, `KP_IDX_CLOCK_CONTROL)) begin
        nxt_st.keypad_clock_enable = pwdata[`KP_CLKCTL_KEYPAD_EN_BIT];
      end
    end

    // Only a flag that was returned to software is cleared, so an event
    // arriving between setup and access is kept; later sets override below.
    if (bus_read_access && addr_is(paddr, `KP_IDX_CONTROL_STATUS) &&
        st_ff.rd_data[`KP_STAT_KEY_FLAG_BIT]) begin
      nxt_st.key_detect_flag = 1'b0;
    end

    if (!st_ff.auto_scan_enable) begin
      // Bypass: the machine parks and the pins follow the column register.
      nxt_st.state = keypad_pkg::ST_WAIT_PRESS;
      nxt_st.col_pins = nxt_st.col_drive;
      if (row_fall_edge) begin
        nxt_st.key_detect_flag = 1'b1;
      end
    end else begin
      nxt_st.col_pins = '0;
      case (st_ff.state)
        keypad_pkg::ST_WAIT_PRESS: begin
          if (any_row_low) begin
            nxt_st.state = keypad_pkg::ST_PRESS_DEBOUNCE;
            nxt_st.timer = debounce_ticks;
          end
        end
        keypad_pkg::ST_PRESS_DEBOUNCE: begin
          if (tick_en) begin
            nxt_st.timer = st_ff.timer - 9'h1;
            if (st_ff.timer == 9'h1) begin
              if (any_row_low) begin
                nxt_st.state = keypad_pkg::ST_SCAN;
                nxt_st.slot = 3'h0;
                nxt_st.row_idx = 3'h0;
                nxt_st.hits = 2'h0;
                nxt_st.timer = row_check_ticks;
                nxt_st.col_pins = {NUM_COLS{1'b1}};
              end else begin
                nxt_st.state = keypad_pkg::ST_WAIT_PRESS;
              end
            end
          end
        end
        keypad_pkg::ST_SCAN: begin
          nxt_st.col_pins = scan_pattern;
          if (tick_en) begin
            nxt_st.timer = st_ff.timer - 9'h1;
            if (st_ff.timer == 9'h1) begin
              nxt_st.timer = row_check_ticks;
              if (!st_ff.row_sync[st_ff.row_idx] && cur_col < MAX_COLS) begin
                nxt_st.hits = (st_ff.hits == 2'h0) ? 2'h1 : 2'h2;
                nxt_st.hit_col = cur_col;
                nxt_st.hit_row = st_ff.row_idx;
              end
              if (st_ff.row_idx == active_rows - 3'h1) begin
                nxt_st.row_idx = 3'h0;
                nxt_st.slot = st_ff.slot + 3'h1;
                if (st_ff.slot == active_cols - 3'h1) begin
                  nxt_st.state = keypad_pkg::ST_WAIT_RELEASE;
                  nxt_st.col_pins = '0;
                  if (nxt_st.hits == 2'h1) begin
                    nxt_st.col_drive = ~(NUM_COLS'(1) << nxt_st.hit_col);
                    nxt_st.row_hold = ~(NUM_ROWS'(1) << nxt_st.hit_row);
                    nxt_st.key_detect_flag = 1'b1;
                  end
                end
              end else begin
                nxt_st.row_idx = st_ff.row_idx + 3'h1;
              end
            end
          end
        end
        keypad_pkg::ST_WAIT_RELEASE: begin
          if (all_rows_high) begin
            nxt_st.state = keypad_pkg::ST_RELEASE_DEBOUNCE;
            nxt_st.timer = debounce_ticks;
          end
        end
        keypad_pkg::ST_RELEASE_DEBOUNCE: begin
          if (tick_en) begin
            nxt_st.timer = st_ff.timer - 9'h1;
            if (st_ff.timer == 9'h1) begin
              if (all_rows_high) begin
                nxt_st.state = keypad_pkg::ST_WAIT_PRESS;
              end else begin
                nxt_st.timer = debounce_ticks;
              end
            end
          end
        end
        default: begin
          nxt_st.state = keypad_pkg::ST_WAIT_PRESS;
        end
      endcase
    end

    // Read data is captured in the setup cycle so prdata comes from a flop.
    if (bus_setup) begin
      nxt_st.rd_data = 8'h00;
      nxt_st.rd_err = 1'b0;
      if (pwrite) begin
        nxt_st.rd_err = ~(addr_is(paddr, `KP_IDX_COLUMN_DRIVE) || addr_is(paddr, `KP_IDX_TIMING) ||
                          addr_is(paddr, `KP_IDX_CONTROL_STATUS) || addr_is(paddr, `KP_IDX_ORDER_LOW) ||
                          addr_is(paddr, `KP_IDX_ORDER_HIGH) || addr_is(paddr, `KP_IDX_DIMENSION) ||
                          addr_is(paddr, `KP_IDX_CLOCK_CONTROL));
      end else if (addr_is(paddr, `KP_IDX_COLUMN_DRIVE)) begin
        nxt_st.rd_data = 8'(st_ff.col_drive);
      end else if (addr_is(paddr, `KP_IDX_ROW_SENSE)) begin
        // Bypass reads the live rows; automatic mode reads the stored key row.
        nxt_st.rd_data = st_ff.auto_scan_enable ? 8'(st_ff.row_hold) : 8'(st_ff.row_sync);
      end else if (addr_is(paddr, `KP_IDX_TIMING)) begin
        nxt_st.rd_data = st_ff.timing;
      end else if (addr_is(paddr, `KP_IDX_CONTROL_STATUS)) begin
        nxt_st.rd_data = {4'h0, st_ff.tick_phase, st_ff.auto_scan_enable,
                          st_ff.key_detect_flag, st_ff.detect_enable};
      end else if (addr_is(paddr, `KP_IDX_ORDER_LOW)) begin
        nxt_st.rd_data = st_ff.order_low[7:0];
      end else if (addr_is(paddr, `KP_IDX_ORDER_HIGH)) begin
        nxt_st.rd_data = 8'(st_ff.order_high);
      end else if (addr_is(paddr, `KP_IDX_DIMENSION)) begin
        nxt_st.rd_data = st_ff.dimension;
      end else if (addr_is(paddr, `KP_IDX_CLOCK_CONTROL)) begin
        nxt_st.rd_data = {1'b0, st_ff.keypad_clock_enable, 6'h00};
      end else begin
        nxt_st.rd_err = 1'b1;
      end
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.state <= keypad_pkg::ST_WAIT_PRESS;
      st_ff.col_drive <= NUM_COLS'(`KP_COLUMN_DRIVE_RESET);
      st_ff.col_pins <= NUM_COLS'(`KP_COLUMN_DRIVE_RESET);
      st_ff.row_hold <= NUM_ROWS'(`KP_ROW_SENSE_RESET);
      st_ff.row_meta <= '1;
      st_ff.row_sync <= '1;
      st_ff.row_prev <= '1;
      st_ff.timing <= `KP_TIMING_RESET;
      st_ff.order_low <= `KP_ORDER_LOW_RESET;
      st_ff.order_high <= `KP_ORDER_HIGH_RESET;
      st_ff.dimension <= `KP_DIMENSION_RESET;
      st_ff.auto_scan_enable <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign prdata = {24'h000000, st_ff.rd_data};
  assign pslverr = st_ff.rd_err & psel & penable;
  // Every access completes without wait states.
  assign pready = 1'b1;
  assign col_out = st_ff.col_pins;
  // The pad cells take these as static enables; the matrix needs no external resistors.
  assign row_pullup_en = '1;
  assign row_hyst_en = '1;
  assign key_irq = st_ff.key_detect_flag & st_ff.detect_enable;

endmodule // keypad_matrix_scanner

`default_nettype wire

// ---- verification/keypad_scanner_asserts.sv ----
// Port checker of the keypad scanner.
// Assumes a bind into keypad_matrix_scanner; it sees that module's ports only.
`include "keypad_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module keypad_scanner_asserts #(
  parameter int NUM_ROWS = 6,
  parameter int NUM_COLS = 5
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_COLS-1:0] col_out,
  input wire logic [NUM_ROWS-1:0] row_pullup_en,
  input wire logic [NUM_ROWS-1:0] row_hyst_en,
  input wire logic key_irq
);
  localparam logic [11:0] A_COL = {`KP_IDX_COLUMN_DRIVE, 2'b00};
  localparam logic [11:0] A_STAT = {`KP_IDX_CONTROL_STATUS, 2'b00};
  localparam logic [11:0] A_ROW = {`KP_IDX_ROW_SENSE, 2'b00};
  logic acc;
  logic hit;
  logic auto_ff;
  logic colw_ff;
  logic [1:0] quiet_ff;
  logic [NUM_COLS-1:0] wcol_ff;
  assign acc = psel && penable;
  assign hit = paddr[1:0] == 2'h0 && paddr[11:2] >= `KP_IDX_COLUMN_DRIVE && paddr[11:2] <= `KP_IDX_CLOCK_CONTROL;

  // ****************************************
  // Shadow of the scan mode and of bypass column writes
  // ****************************************
  // The column pins are only judged once three quiet cycles have passed, so the write latency stays free.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      auto_ff <= 1'b0;
      colw_ff <= 1'b1;
      quiet_ff <= 2'h0;
      wcol_ff <= '1;
    end else if (acc && pwrite && paddr == A_STAT) begin
      auto_ff <= pwdata[2];
      colw_ff <= 1'b0;
      quiet_ff <= 2'h0;
    end else if (acc && pwrite && paddr == A_COL) begin
      colw_ff <= !auto_ff;
      wcol_ff <= pwdata[NUM_COLS-1:0];
      quiet_ff <= 2'h0;
    end else if (quiet_ff != 2'h3) begin
      quiet_ff <= quiet_ff + 2'h1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  ready_high_a: assert property (pready) else $error("pready low");
  err_access_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
  // The row register is read-only, so a write to it is refused like a miss.
  err_decode_a: assert property (acc |-> pslverr == !(hit && !(pwrite && paddr == A_ROW)))
    else $error("pslverr decode wrong");
  rdata_clean_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0 && (hit || prdata == 32'h0))
    else $error("read data not clean");
  row_pins_a: assert property (row_pullup_en == '1 && row_hyst_en == '1) else $error("row pull-up off");
  reset_idle_a: assert property ($rose(reset_n) |-> col_out == '1 && !key_irq) else $error("bad idle");
  col_hold_a: assert property (quiet_ff == 2'h3 && !auto_ff && !(acc && pwrite) |=> $stable(col_out))
    else $error("column drive moved");
  one_column_a: assert property (quiet_ff == 2'h3 && auto_ff |-> col_out == '0 || $onehot0(~col_out))
    else $error("more than one column driven in scan");
  col_value_a: assert property (quiet_ff == 2'h3 && colw_ff |-> col_out == wcol_ff)
    else $error("column drive not the register");
  flag_clear_a: assert property (acc && !pwrite && paddr == A_STAT && prdata[1] |=> !key_irq)
    else $error("flag kept after read");
endmodule // keypad_scanner_asserts
`default_nettype wire

// ---- verification/keypad_switch_matrix.sv ----
// Switch matrix on the far side of the keypad scanner.
// Assumes one key_down bit per switch at index row * NUM_COLS + column.
`timescale 1ns/1ps
`default_nettype none

module keypad_switch_matrix #(
  parameter int NUM_ROWS = 6,
  parameter int NUM_COLS = 5
) (
  input wire logic [NUM_COLS-1:0] col_out,
  input wire logic [NUM_ROWS*NUM_COLS-1:0] key_down,
  output logic [NUM_ROWS-1:0] row_in
);
  // A closed switch ties its row to its column; these switches never bounce.
  always_comb begin
    row_in = '1;
    for (int r = 0; r < NUM_ROWS; r++) begin
      for (int c = 0; c < NUM_COLS; c++) begin
        if (key_down[r*NUM_COLS+c] && !col_out[c]) begin
          row_in[r] = 1'b0;
        end
      end
    end
  end
endmodule // keypad_switch_matrix
`default_nettype wire

// ---- verification/tb_keypad_matrix_scanner.sv ----
// Testbench of the keypad scanner: APB register tasks over bypass and automatic scanning.
// Assumes the design, the switch matrix model and the checker are compiled before it.
`include "keypad_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_keypad_matrix_scanner;
  localparam logic [11:0] A_COL = {`KP_IDX_COLUMN_DRIVE, 2'b00};
  localparam logic [11:0] A_ROW = {`KP_IDX_ROW_SENSE, 2'b00};
  localparam logic [11:0] A_STAT = {`KP_IDX_CONTROL_STATUS, 2'b00};
  localparam logic [11:0] A_CLK = {`KP_IDX_CLOCK_CONTROL, 2'b00};
  localparam logic [11:0] A_DIM = {`KP_IDX_DIMENSION, 2'b00};
  localparam logic [7:0] RST_VAL [8] = '{8'h1f, 8'h3f, 8'h00, 8'h00, 8'h88, 8'h23, 8'h65, 8'h00};
  logic clk_sys;
  logic reset_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tick_1khz;
  logic [5:0] row_in;
  logic [4:0] col_out;
  logic key_irq;
  logic [29:0] key_down;
  logic [2:0] tick_cnt;
  logic [31:0] rdat;
  logic rerr;
  int num_errors;
  int n_checks;
  int n;

  keypad_matrix_scanner #(.NUM_ROWS(6), .NUM_COLS(5)) i_keypad_matrix_scanner (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick_1khz(tick_1khz), .row_in(row_in), .col_out(col_out), .row_pullup_en(), .row_hyst_en(),
    .key_irq(key_irq));
  keypad_switch_matrix #(.NUM_ROWS(6), .NUM_COLS(5)) i_keypad_switch_matrix (
    .col_out(col_out), .key_down(key_down), .row_in(row_in));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Ticks come every eight clocks instead of every millisecond, to keep the run short.
  always @(posedge clk_sys) begin
    tick_cnt <= tick_cnt + 3'h1;
    tick_1khz <= tick_cnt == 3'h7;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    check($sformatf("read at %h", a), exp, rdat);
    check("pslverr", 32'(err), 32'(rerr));
  endtask

  task automatic col_chk(input logic [4:0] exp);
    repeat (2) @(negedge clk_sys);
    check("col_out", 32'(exp), 32'(col_out));
  endtask

  task automatic press(input logic [29:0] k);
    @(posedge clk_sys);
    key_down <= k;
  endtask

  task automatic wait_irq(input int lim);
    n = 0;
    while (key_irq !== 1'b1 && n < lim) begin
      n++;
      @(negedge clk_sys);
    end
    check("key_irq", 32'h1, 32'(key_irq));
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Reset values, bypass scanning, automatic scanning
  // ****************************************
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tick_1khz = 1'b0;
    tick_cnt = 3'h0;
    key_down = '0;
    num_errors = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(A_COL + 12'(4 * i), 32'(RST_VAL[i]), 1'b0);
    rd(12'h400, 32'h0, 1'b1);
    rd(A_COL + 12'h002, 32'h0, 1'b1);
    apb(1'b1, A_ROW, 32'h0);
    check("pslverr", 32'h1, 32'(rerr));
    rd(A_ROW, 32'h3f, 1'b0);
    apb(1'b1, A_STAT, 32'h1);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, A_COL, k ? 32'h0f : 32'h1e);
      col_chk(k ? 5'h0f : 5'h1e);
      press(k ? 30'h2000_0000 : 30'h1);
      wait_irq(20);
      rd(A_ROW, k ? 32'h1f : 32'h3e, 1'b0);
      rd(A_STAT, 32'h3, 1'b0);
      rd(A_STAT, 32'h1, 1'b0);
      press(30'h0);
    end
    apb(1'b1, A_CLK, 32'h40);
    apb(1'b1, {`KP_IDX_TIMING, 2'b00}, 32'h05);
    apb(1'b1, {`KP_IDX_ORDER_LOW, 2'b00}, 32'h00a);
    apb(1'b1, A_STAT, 32'h5);
    col_chk(5'h00);
    press(30'h1 << 17);
    n = 0;
    // One all-high cycle separates the idle drive from the first scanned column.
    while ((col_out === 5'h00 || col_out === 5'h1f) && n < 400) begin
      n++;
      @(negedge clk_sys);
    end
    check("debounce span", 32'h1, 32'(n >= 24 && n <= 48));
    check("first scanned column", 32'h1b, 32'(col_out));
    wait_irq(1000);
    apb(1'b0, A_STAT, 32'h0);
    check("status", 32'h7, rdat & 32'h7);
    apb(1'b0, A_STAT, 32'h0);
    check("status", 32'h5, rdat & 32'h7);
    rd(A_COL, 32'h1b, 1'b0);
    rd(A_ROW, 32'h37, 1'b0);
    col_chk(5'h00);
    press(30'h0);
    repeat (200) @(posedge clk_sys);
    press(30'h2000_0001);
    repeat (600) @(negedge clk_sys);
    check("key_irq", 32'h0, 32'(key_irq));
    rd(A_ROW, 32'h37, 1'b0);
    press(30'h0);
    repeat (200) @(posedge clk_sys);
    // Three columns only: a key on the fifth column must go unreported.
    apb(1'b1, A_DIM, 32'h63);
    press(30'h10);
    repeat (400) @(negedge clk_sys);
    check("key_irq", 32'h0, 32'(key_irq));
    rd(A_ROW, 32'h37, 1'b0);
    press(30'h0);
    repeat (200) @(posedge clk_sys);
    apb(1'b1, A_DIM, 32'h65);
    rd(A_DIM, 32'h65, 1'b0);
    apb(1'b1, A_CLK, 32'h0);
    press(30'h1 << 17);
    repeat (300) @(negedge clk_sys);
    check("key_irq", 32'h0, 32'(key_irq));
    col_chk(5'h00);
    apb(1'b1, A_CLK, 32'h40);
    wait_irq(1000);
    apb(1'b1, A_STAT, 32'h1);
    col_chk(5'h1b);
    press(30'h0);
    repeat (20) @(posedge clk_sys);
    finish_test();
  end
endmodule // tb_keypad_matrix_scanner

bind keypad_matrix_scanner keypad_scanner_asserts #(.NUM_ROWS(NUM_ROWS), .NUM_COLS(NUM_COLS)) i_keypad_scanner_asserts (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .col_out(col_out),
  .row_pullup_en(row_pullup_en), .row_hyst_en(row_hyst_en), .key_irq(key_irq));
`default_nettype wire
